// [core/atr_adc_control.sv]
// converter control: triggers, start delay, sequencer, result port and panel drivers
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
// Summary of operation
// - a write to the start port makes a trigger unless the external source is selected; data ignored
// - external trigger fires on the edge chosen by the polarity bit
// - external trigger is glitch filtered; one-clock (100 ns) pulses still pass
// - once a trigger is accepted, all triggers ignored until conversion completes
// - automatic mode converts on every qualified edge unless busy
// - non-automatic mode needs a start write to prime; one edge per priming
// - after trigger, wait start delay count periods, then start the sequencer
// - sequencer converts, pushes the result into the queue, signals done
// - four-deep result queue, head at result port; each read pops
// - result into full queue sets overflow and is discarded
// - done and interrupt high while queue non-empty; interrupt low one clock after read, done stays high
// - wake output follows the same rule but rises before the interrupt
// - in pen-down mode wake output is done ORed with pen detector
// - panel code 101b enables pen mode and shows pen state in result port
// - clock source bit picks divided system clock or auxiliary clock 2
// - selected clock delayed by clock delay count units drives the converter
// - divider on the converter clock times the start delay stage
// - result queue runs on the system clock
// - input select steers the mux; external select picks mux or pin
// - code 010b drives X plate ends, 001b drives Y plate ends
// - code 100b drives Y high end and X low end for contact resistance
// - positive and negative reference select fields steer the reference muxes
// - clearing clock enable stops clocks, resets sequencer, cancels triggers
// - under emulation halt, result reads clear nothing; queue and done run on
module atr_adc_control
  import atr_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int DATA_W     = 12
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [15:0]       regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [15:0]       regRdData,
  // trigger, clock and emulation inputs
  input  wire logic              extTrigIn,
  input  wire logic              auxClk2,
  input  wire logic              emuHalt,
  // converter core
  input  wire logic              convDone,
  input  wire logic [DATA_W-1:0] convData,
  input  wire logic              penDetect,
  output logic                   convStart,
  output logic                   convClkEn,
  output logic                   convPowerUp,
  // analog path control
  output logic      [2:0]        inputSelect,
  output logic                   externalInputSelect,
  output logic                   diffMode,
  output logic                   muxOutEnable,
  output logic      [1:0]        positiveRefSelect,
  output logic      [1:0]        negativeRefSelect,
  output logic                   xPlateHigh,
  output logic                   xPlateLow,
  output logic                   yPlateHigh,
  output logic                   yPlateLow,
  // system outputs
  output logic                   converterIrq,
  output logic                   wakeInputLine
);
  logic [15:0]       gcr_r;
  logic [15:0]       acr_r;
  logic [15:0]       ctl_r;
  logic [15:0]       sdl_r;
  logic              ovf_r;
  logic [15:0]       rdData_r;
  atr_state_t        state_r;
  atr_state_t        state_nxt;
  logic [7:0]        dlyCnt_r;
  logic              primed_r;
  logic [DATA_W-1:0] res_r;
  logic [3:0]        sysDivCnt_r;
  logic [3:0]        adcDivCnt_r;
  logic              auxPrev_r;
  logic [15:0]       clkDly_r;
  logic              adcTick_r;
  logic [GLITCH_CYC-1:0] extHist_r;
  logic              extFilt_r;
  logic              extFiltD_r;
  logic              convStart_r;
  logic              irq_r;
  logic              wake_r;
  logic [9:0]        anaCfg_r;
  logic [3:0]        plate_r;
  logic [DATA_W-1:0] fifoHead;
  logic              fifoEmpty;
  logic              fifoFull;

  // register decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  wire converter_clock_enable     = gcr_r[B_CONVERTER_CLOCK_ENABLE];
  wire wrGcr     = regWrite && hit(regAddr, OFF_GCR);
  wire wrAcr     = regWrite && hit(regAddr, OFF_ACR);
  // other registers are locked while the converter is disabled
  wire wrCtl     = regWrite && converter_clock_enable && hit(regAddr, OFF_CTL);
  wire wrSdl     = regWrite && converter_clock_enable && hit(regAddr, OFF_SDL);
  wire wrStart   = regWrite && converter_clock_enable && hit(regAddr, OFF_START);
  wire rdResult  = regRead && hit(regAddr, OFF_RES);
  wire clrOnRead = rdResult && !emuHalt;
  wire [2:0] panelSel  = gcr_r[F_PANEL_LO +: 3];
  wire       penMode   = (panelSel == PANEL_PEN);
  wire       penShown  = penMode && penDetect;

  // converter clock: divided system clock or auxiliary clock 2, then delayed
  wire [3:0] sysDiv    = acr_r[F_SYSDIV_LO +: 4];
  wire [3:0] adcDiv    = acr_r[F_ADCDIV_LO +: 4];
  wire [3:0] clkDlySel = sdl_r[F_CDLY_LO +: 4];
  wire       sysTick   = (sysDivCnt_r == 4'h0);
  wire       auxRise   = auxClk2 && !auxPrev_r;
  wire       srcTick   = acr_r[B_CLOCK_SOURCE_SELECT] ? auxRise : sysTick;
  wire [16:0] dlyTap   = {clkDly_r, srcTick};
  wire       adcTickNxt = converter_clock_enable && dlyTap[clkDlySel];
  // start delay stage is timed by a divider of the converter clock
  wire       delayTick = adcTick_r && (adcDivCnt_r == 4'h0);

  // trigger path
  wire       extAllSame = (&extHist_r) || !(|extHist_r);
  wire [GLITCH_CYC:0] extShift = {extHist_r, extTrigIn};
  wire       extRise    = extFilt_r && !extFiltD_r;
  wire       extFall    = !extFilt_r && extFiltD_r;
  wire       extEdge    = ctl_r[B_POL] ? extFall : extRise;
  wire       extSrc     = ctl_r[B_TRIGEXT];
  wire       extArmed   = ctl_r[B_AUTO] || primed_r;
  wire       softTrig   = wrStart && !extSrc;
  wire       extTrig    = converter_clock_enable && extSrc && extArmed && extEdge;
  wire       isIdle     = (state_r == ST_IDLE);
  wire       trigAccept = isIdle && (softTrig || extTrig);
  wire       seqPush    = (state_r == ST_FILL);
  wire       fifoPop    = clrOnRead;
  wire       ovfSet     = seqPush && fifoFull && !fifoPop;
  wire       nonEmptySoon = !fifoEmpty || seqPush;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (trigAccept) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (dlyCnt_r == 8'h00) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (convDone) begin
          state_nxt = ST_FILL;
        end
      end
      ST_FILL: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gcr_r <= GCR_RST;
      acr_r <= ACR_RST;
      ctl_r <= CTL_RST;
      sdl_r <= SDL_RST;
    end else begin
      if (wrGcr) gcr_r <= regWrData;
      if (wrAcr) acr_r <= regWrData;
      if (wrCtl) ctl_r <= regWrData;
      if (wrSdl) sdl_r <= regWrData;
    end
  end

  // overflow: a clearing read frees a slot, so a same-cycle push never sets it and the read clears it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ovf_r <= 1'b0;
    end else if (ovfSet) begin
      ovf_r <= 1'b1;
    end else if (clrOnRead) begin
      ovf_r <= 1'b0;
    end
  end

  // read data one cycle after the strobe
  wire [15:0] resWord = {!fifoEmpty, ovf_r, penShown, 1'b0, fifoHead};
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdData_r <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        OFF_GCR: rdData_r <= gcr_r;
        OFF_ACR: rdData_r <= acr_r;
        OFF_CTL: rdData_r <= ctl_r;
        OFF_SDL: rdData_r <= sdl_r;
        OFF_RES: rdData_r <= resWord;
        default: rdData_r <= 16'h0000;
      endcase
    end else begin
      rdData_r <= 16'h0000;
    end
  end

  // clock generation, all ticks derived from ref_clk so no crossing is needed
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !converter_clock_enable) begin
      sysDivCnt_r <= 4'h0;
      adcDivCnt_r <= 4'h0;
      auxPrev_r   <= 1'b0;
      clkDly_r    <= 16'h0000;
      adcTick_r   <= 1'b0;
    end else begin
      sysDivCnt_r <= sysTick ? sysDiv : sysDivCnt_r - 4'h1;
      auxPrev_r   <= auxClk2;
      clkDly_r    <= {clkDly_r[14:0], srcTick};
      adcTick_r   <= adcTickNxt;
      if (adcTick_r) begin
        adcDivCnt_r <= (adcDivCnt_r == 4'h0) ? adcDiv : adcDivCnt_r - 4'h1;
      end
    end
  end

  // glitch filter: level accepted after GLITCH_CYC equal samples
  // a one-clock pulse already exceeds the minimum width, so it must pass
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      extHist_r  <= '0;
      extFilt_r  <= 1'b0;
      extFiltD_r <= 1'b0;
    end else begin
      extHist_r  <= extShift[GLITCH_CYC-1:0];
      extFiltD_r <= extFilt_r;
      if (extAllSame) begin
        extFilt_r <= extHist_r[0];
      end
    end
  end

  // sequencer, trigger priming and start delay
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !converter_clock_enable) begin
      state_r     <= ST_IDLE;
      primed_r    <= 1'b0;
      dlyCnt_r    <= 8'h00;
      convStart_r <= 1'b0;
      res_r       <= '0;
    end else begin
      state_r     <= state_nxt;
      convStart_r <= (state_r == ST_WAIT) && (state_nxt == ST_CONV);
      if (trigAccept) begin
        dlyCnt_r <= sdl_r[F_SDLY_LO +: 8];
      end else if ((state_r == ST_WAIT) && delayTick && (dlyCnt_r != 8'h00)) begin
        dlyCnt_r <= dlyCnt_r - 8'h01;
      end
      if ((state_r == ST_CONV) && convDone) begin
        res_r <= convData;
      end
      // priming is used up by the accepted edge
      if (trigAccept && extTrig) begin
        primed_r <= 1'b0;
      end else if (wrStart && extSrc && !ctl_r[B_AUTO] && isIdle) begin
        primed_r <= 1'b1;
      end
    end
  end

  // interrupt and wake; wake looks one cycle ahead so it rises first
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r  <= gcr_r[B_INTEN] && !fifoEmpty && !clrOnRead;
      wake_r <= (nonEmptySoon && !clrOnRead) || penShown;
    end
  end

  // analog path and panel drivers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      anaCfg_r <= 10'h000;
      plate_r  <= 4'h0;
    end else begin
      anaCfg_r <= {gcr_r[B_MUXOUTEN], gcr_r[F_NREF_LO +: 2], gcr_r[F_PREF_LO +: 2],
                   gcr_r[B_DIFF], gcr_r[B_EXTIN], gcr_r[F_MUX_LO +: 3]};
      case (panelSel)
        PANEL_X: plate_r <= 4'b1100;
        PANEL_Y: plate_r <= 4'b0011;
        PANEL_Z: plate_r <= 4'b0110;
        default: plate_r <= 4'b0000;
      endcase
    end
  end

  atr_result_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .flush     (1'b0),
    .pushValid (seqPush),
    .pushData  (res_r),
    .popReq    (fifoPop),
    .headData  (fifoHead),
    .empty     (fifoEmpty),
    .full      (fifoFull)
  );

  assign regRdData           = rdData_r;
  assign convStart           = convStart_r;
  assign convClkEn           = adcTick_r;
  assign convPowerUp         = gcr_r[B_CONVERTER_CLOCK_ENABLE];
  assign inputSelect         = anaCfg_r[2:0];
  assign externalInputSelect = anaCfg_r[3];
  assign diffMode            = anaCfg_r[4];
  assign positiveRefSelect   = anaCfg_r[6:5];
  assign negativeRefSelect   = anaCfg_r[8:7];
  assign muxOutEnable        = anaCfg_r[9];
  assign xPlateHigh          = plate_r[3];
  assign xPlateLow           = plate_r[2];
  assign yPlateHigh          = plate_r[1];
  assign yPlateLow           = plate_r[0];
  assign converterIrq        = irq_r;
  assign wakeInputLine       = wake_r;

  // checks
  sequence s_waitExpire;
    (state_r == ST_WAIT) && (dlyCnt_r == 8'h00) && converter_clock_enable;
  endsequence
  sequence s_convEntry;
    (state_r == ST_CONV) && convStart_r;
  endsequence

  a_soft_trigger: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (softTrig && isIdle) |=> (state_r == ST_WAIT))
    else $error("start write did not trigger");
  a_busy_ignore: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ((state_r == ST_WAIT) && (dlyCnt_r != 8'h00) && converter_clock_enable && !wrGcr) |=>
      ((state_r == ST_WAIT) && ($past(dlyCnt_r) - dlyCnt_r <= 8'h01)))
    else $error("trigger retaken while busy");
  a_unprimed_edge: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (isIdle && extSrc && !ctl_r[B_AUTO] && !primed_r && !wrStart) |=> isIdle || !converter_clock_enable)
    else $error("unprimed edge started a conversion");
  a_delay_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_waitExpire |=> s_convEntry ##1 !convStart_r)
    else $error("start pulse missing after delay");
  a_filter_glitch: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (extFilt_r != $past(extFilt_r)) |-> $past(extAllSame))
    else $error("filtered trigger followed a glitch");
  a_overflow_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ovfSet |=> ovf_r && fifoFull)
    else $error("overflow not flagged");
  a_irq_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clrOnRead && gcr_r[B_INTEN]) |=> !irq_r)
    else $error("interrupt did not drop after read");
  a_wake_early: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!irq_r && gcr_r[B_INTEN] && !wrGcr && seqPush && fifoEmpty && !clrOnRead) |=>
      wake_r && !irq_r ##1 (irq_r || $past(clrOnRead) || $past(wrGcr)))
    else $error("wake did not lead interrupt");
  a_pen_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
    penShown |=> wake_r)
    else $error("pen down not on wake line");
  a_disable_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !converter_clock_enable |=> isIdle && !primed_r && !adcTick_r)
    else $error("disable did not reset sequencer");
  a_halt_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rdResult && emuHalt && ovf_r) |=> ovf_r)
    else $error("read under halt cleared status");
endmodule

// [include/atr_pkg.sv]
// constants shared by the converter trigger, sequencer and result queue
package atr_pkg;
  // register offsets, 16-bit registers at printed offsets
  localparam logic [3:0]  OFF_GCR   = 4'h0;
  localparam logic [3:0]  OFF_ACR   = 4'h2;
  localparam logic [3:0]  OFF_CTL   = 4'h4;
  localparam logic [3:0]  OFF_START = 4'h6;
  localparam logic [3:0]  OFF_SDL   = 4'h8;
  localparam logic [3:0]  OFF_RES   = 4'hA;
  // reset values
  localparam logic [15:0] GCR_RST   = 16'h0000;
  localparam logic [15:0] ACR_RST   = 16'h0000;
  localparam logic [15:0] CTL_RST   = 16'h0000;
  localparam logic [15:0] SDL_RST   = 16'h0000;
  // global_analog_config fields
  localparam int B_CONVERTER_CLOCK_ENABLE     = 0;
  localparam int B_EXTIN     = 1;
  localparam int B_DIFF      = 2;
  localparam int F_MUX_LO    = 3;
  localparam int F_PANEL_LO  = 6;
  localparam int F_PREF_LO   = 9;
  localparam int F_NREF_LO   = 11;
  localparam int B_INTEN     = 14;
  localparam int B_MUXOUTEN  = 15;
  // panel_driver_select codes
  localparam logic [2:0] PANEL_X   = 3'h2;
  localparam logic [2:0] PANEL_Y   = 3'h1;
  localparam logic [2:0] PANEL_Z   = 3'h4;
  localparam logic [2:0] PANEL_PEN = 3'h5;
  // auxiliary_config fields
  localparam int B_CLOCK_SOURCE_SELECT    = 0;
  localparam int F_SYSDIV_LO = 4;
  localparam int F_ADCDIV_LO = 8;
  // conversion_control fields
  localparam int B_TRIGEXT   = 0;
  localparam int B_AUTO      = 1;
  localparam int B_POL       = 2;
  // start_delay_config fields
  localparam int F_SDLY_LO   = 0;
  localparam int F_CDLY_LO   = 8;
  // conversion_result_port fields
  localparam int B_PEN       = 13;
  localparam int B_OVF       = 14;
  localparam int B_DONE      = 15;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int GLITCH_NS     = 10;
  localparam int GLITCH_RAW    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC    = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_CONV = 4'h4,
    ST_FILL = 4'h8
  } atr_state_t;
endpackage

// [core/atr_result_fifo.sv]
// result queue on the system clock, head visible combinationally
`timescale 1ns/10ps
module atr_result_fifo
  import atr_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  // write side
  input  wire logic             pushValid,
  input  wire logic [WIDTH-1:0] pushData,
  // read side
  input  wire logic             popReq,
  output logic      [WIDTH-1:0] headData,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  wire              doPop  = popReq && !empty;
  // a push into a full queue is dropped unless a pop frees the slot in the same cycle
  wire              doPush = pushValid && (!full || doPop);
  wire [AW-1:0]     wrNext = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
  wire [AW-1:0]     rdNext = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;

  assign empty    = (count_r == '0);
  assign full     = (count_r == (AW+1)'(DEPTH));
  assign headData = mem[rdPtr_r];

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= pushData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrNext;
      end
      if (doPop) begin
        rdPtr_r <= rdNext;
      end
      count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule

// [verif/atr_conv_model.sv]
// behavioural converter core: answers each start with one result after a fixed latency
`timescale 1ns/10ps
module atr_conv_model #(
  parameter int LAT = 6
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // core handshake
  input  wire logic        convStart,
  output logic             convDone,
  output logic      [11:0] convData
);
  int          cnt;
  logic [11:0] seq_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt      <= 0;
      convDone <= 1'b0;
      convData <= 12'h000;
      seq_r    <= 12'h100;
    end else begin
      convDone <= 1'b0;
      // data is only valid beside done; toggle otherwise so a stale capture shows
      convData <= ~convData;
      if (convStart) begin
        cnt <= LAT;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt      <= 0;
        convDone <= 1'b1;
        convData <= seq_r;
        seq_r    <= seq_r + 12'h001;
      end
    end
  end
endmodule

// [verif/adc_trigger_result_control_tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/10ps
module adc_trigger_result_control_tb;
  import atr_pkg::*;
  typedef struct packed {
    logic [15:0] gcr;
    logic        pen;
    logic [3:0]  plates;
    logic        wake;
  } atr_row_t;
  typedef struct {
    logic [15:0] acr;
    logic [15:0] sdl;
    int          lo;
    int          hi;
  } atr_dly_t;
  // panel codes, mux and reference fields, pen input
  atr_row_t rows [7] = '{'{16'h4C9B, 1'b0, 4'hC, 1'b0}, '{16'h5269, 1'b0, 4'h3, 1'b0},
    '{16'h473B, 1'b0, 4'h6, 1'b0}, '{16'h4141, 1'b1, 4'h0, 1'b1}, '{16'h4141, 1'b0, 4'h0, 1'b0},
    '{16'hC005, 1'b1, 4'h0, 1'b0}, '{16'h41C1, 1'b1, 4'h0, 1'b0}};
  // extra cycles over the zero-delay latency: divided ticks land with any phase
  atr_dly_t dly [4] = '{'{16'h0000, 16'h0308, 8, 8}, '{16'h0100, 16'h0004, 7, 9},
    '{16'h0010, 16'h0004, 7, 9}, '{16'h0001, 16'h0004, 18, 26}};
  logic        ref_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [3:0]  regAddr   = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrite  = 1'b0;
  logic        regRead   = 1'b0;
  logic        extTrigIn = 1'b0;
  logic        auxClk2   = 1'b0;
  logic        emuHalt   = 1'b0;
  logic        penDetect = 1'b0;
  logic        convDone, convStart, convClkEn, convPowerUp, externalInputSelect, diffMode;
  logic        muxOutEnable, xPlateHigh, xPlateLow, yPlateHigh, yPlateLow, converterIrq, wakeInputLine;
  logic [11:0] convData;
  logic [15:0] regRdData, word;
  logic [2:0]  inputSelect;
  logic [1:0]  positiveRefSelect, negativeRefSelect, lines;
  logic [11:0] expData = 12'h100;
  int          fails   = 0;
  int          checks  = 0;

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  // auxiliary clock 2 at one sixth of the system rate
  always begin
    repeat (3) @(posedge ref_clk);
    auxClk2 <= ~auxClk2;
  end

  atr_adc_control atr_adc_control_inst (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .extTrigIn(extTrigIn), .auxClk2(auxClk2), .emuHalt(emuHalt), .convDone(convDone),
    .convData(convData), .penDetect(penDetect), .convStart(convStart), .convClkEn(convClkEn),
    .convPowerUp(convPowerUp), .inputSelect(inputSelect), .externalInputSelect(externalInputSelect),
    .diffMode(diffMode), .muxOutEnable(muxOutEnable), .positiveRefSelect(positiveRefSelect),
    .negativeRefSelect(negativeRefSelect), .xPlateHigh(xPlateHigh), .xPlateLow(xPlateLow),
    .yPlateHigh(yPlateHigh), .yPlateLow(yPlateLow), .converterIrq(converterIrq),
    .wakeInputLine(wakeInputLine));
  atr_conv_model atr_conv_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .convStart(convStart),
    .convDone(convDone), .convData(convData));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge ref_clk);
    regWrite  <= 1'b0;
  endtask
  // read data and both request lines are taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    word  = regRdData;
    lines = {converterIrq, wakeInputLine};
  endtask
  task automatic trig(output int lat);
    lat = 0;
    wr(OFF_START, 16'hA5A5);
    while (convStart !== 1'b1 && lat < 400) begin
      @(posedge ref_clk);
      lat++;
    end
    repeat (14) @(posedge ref_clk);
  endtask
  task automatic starts(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (convStart === 1'b1) c++;
    end
  endtask
  task automatic pulse(input logic v);
    @(posedge ref_clk);
    extTrigIn <= v;
    @(posedge ref_clk);
    extTrigIn <= ~v;
  endtask
  task automatic drain(input int n);
    repeat (n) begin
      rd(OFF_RES);
      chk(word, {4'h8, expData});
      expData++;
    end
    rd(OFF_RES);
    chk({word[15:14], 14'h0000}, 16'h0000);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done;
  end

  initial begin
    int baseLat, lat, c;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(OFF_GCR);
    chk(word, GCR_RST);
    rd(4'hE);
    chk(word, 16'h0000);
    wr(OFF_SDL, 16'h0005);
    wr(OFF_GCR, 16'h4001);
    rd(OFF_SDL);
    chk(word, SDL_RST);
    $display("test reset done");
    foreach (rows[i]) begin
      penDetect <= rows[i].pen;
      wr(OFF_GCR, rows[i].gcr);
      repeat (2) @(posedge ref_clk);
      chk({12'h000, xPlateHigh, xPlateLow, yPlateHigh, yPlateLow}, {12'h000, rows[i].plates});
      chk({6'h00, muxOutEnable, diffMode, inputSelect, externalInputSelect, positiveRefSelect, negativeRefSelect},
          {6'h00, rows[i].gcr[15], rows[i].gcr[2], rows[i].gcr[5:3], rows[i].gcr[1], rows[i].gcr[10:9],
           rows[i].gcr[12:11]});
      chk({15'h0000, wakeInputLine}, {15'h0000, rows[i].wake});
      rd(OFF_RES);
      chk({13'h0000, word[15:13]}, {15'h0000, rows[i].wake});
    end
    $display("test configuration rows done");
    penDetect <= 1'b0;
    wr(OFF_GCR, 16'h4001);
    trig(baseLat);
    chk({14'h0000, convClkEn, convPowerUp}, 16'h0003);
    foreach (dly[i]) begin
      wr(OFF_ACR, dly[i].acr);
      wr(OFF_SDL, dly[i].sdl);
      trig(lat);
      chk({15'h0000, lat >= baseLat + dly[i].lo && lat <= baseLat + dly[i].hi}, 16'h0001);
    end
    $display("test start delay done");
    wr(OFF_ACR, 16'h0000);
    // five results into four places: the last one is lost
    chk({14'h0000, converterIrq, wakeInputLine}, 16'h0003);
    emuHalt <= 1'b1;
    repeat (2) begin
      rd(OFF_RES);
      chk(word, {4'hC, expData});
      chk({14'h0000, lines}, 16'h0003);
    end
    emuHalt <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      rd(OFF_RES);
      chk(word, {1'b1, k == 0, 2'b00, expData});
      chk({14'h0000, lines}, 16'h0000);
      expData++;
    end
    expData++;
    $display("test queue overflow done");
    wr(OFF_SDL, 16'h0014);
    wr(OFF_START, 16'h0001);
    wr(OFF_START, 16'h0002);
    starts(60, c);
    chk(c[15:0], 16'h0001);
    drain(1);
    wr(OFF_START, 16'h0003);
    wr(OFF_GCR, 16'h4000);
    starts(40, c);
    chk(c[15:0], 16'h0000);
    chk({14'h0000, convClkEn, convPowerUp}, 16'h0000);
    wr(OFF_GCR, 16'h4001);
    $display("test refusal and cancel done");
    wr(OFF_SDL, 16'h0000);
    wr(OFF_CTL, 16'h0003);
    repeat (2) begin
      pulse(1'b1);
      starts(30, c);
      chk(c[15:0], 16'h0001);
    end
    wr(OFF_CTL, 16'h0007);
    extTrigIn <= 1'b1;
    starts(20, c);
    chk(c[15:0], 16'h0000);
    pulse(1'b0);
    starts(30, c);
    chk(c[15:0], 16'h0001);
    wr(OFF_CTL, 16'h0005);
    pulse(1'b0);
    starts(30, c);
    chk(c[15:0], 16'h0000);
    wr(OFF_START, 16'h0000);
    pulse(1'b0);
    starts(30, c);
    chk(c[15:0], 16'h0001);
    pulse(1'b0);
    starts(30, c);
    chk(c[15:0], 16'h0000);
    drain(4);
    $display("test external trigger done");
    test_done;
  end
endmodule
